// file: hdl/tuner_link_master.sv
/*
  Bus master for the tuner's two-wire register port: register writes with
  auto-advance, and reads through a repeated start.
  Assumes open-drain pins with external pull-ups; pins are sensed through
  tuner_pin_sync and the serial clock is divided down from clk.
*/
// Overview of operation
// - acknowledge means data low before the ninth rising edge, held through high phase.
// - not-acknowledge means data released high before and during the ninth high phase.
// - on a missing acknowledge the master abandons the transfer with a stop and sets nack_error.
// - the bit after the address picks direction: zero write, one read.
// - write: after address acknowledge the master sends the start register index.
// - data bytes go most significant bit first; each stored byte is acknowledged.
// - a write stays open until the master sends a stop.
// - read: address with write bit, index, repeated start, address with read bit.
// - master acknowledges each read byte to continue, or not-acknowledges to end.
// - a read stays open until the stop after the final not-acknowledge.
// - start is data falling with clock high; stop is data rising with clock high.
// - data holds steady while the clock is high.
// - the master makes the serial clock, never faster than 400 kHz.
module tuner_link_master #(
  parameter int QC = tuner_link_pkg::QUARTER_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic read_not_write,
  input wire logic bus_address_select_pin,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] byte_count,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic done,
  output logic nack_error,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import tuner_link_pkg::*;

  localparam int DIV_W = $clog2(QC + 1);

  typedef struct packed {
    phase_t ph;
    logic [1:0] q;
    logic [DIV_W-1:0] div;
    logic [2:0] bitc;
    logic [7:0] sh;
    byte_kind_t kind;
    logic rw;
    logic sel;
    logic [7:0] idx;
    logic [7:0] left;
    logic mack_low;
    logic scl_low;
    logic sda_low;
    logic [7:0] rd_data;
    logic rd_valid;
    logic wr_take;
    logic done;
    logic nack;
    logic [DIV_W+1:0] low_cnt;
  } state_t;

  state_t st;
  state_t next_st;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic hold;
  logic smp;
  logic slot_end;

  tuner_pin_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({scl_in, sda_in}),
    .q(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // {scl_low, sda_low} per phase and quarter; quarters 1 and 2 are clock high
  function automatic logic [1:0] line_drive(input phase_t ph, input logic [1:0] q,
                                            input logic bit7, input logic mack,
                                            input logic restart);
    logic edge_q;
    edge_q = (q == 2'h0) || (q == 2'h3);
    case (ph)
      PH_IDLE: line_drive = 2'h0;
      // repeated start keeps the clock low one more quarter, else the low phase is too short
      PH_START: line_drive = {(q == 2'h3) || (restart && q == 2'h0), q >= 2'h2};
      PH_STOP: line_drive = {q == 2'h0, q <= 2'h1};
      PH_TXB: line_drive = {edge_q, ~bit7};
      PH_MACK: line_drive = {edge_q, mack};
      default: line_drive = {edge_q, 1'h0};
    endcase
  endfunction : line_drive

  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'h0;
    next_st.wr_take = 1'h0;
    next_st.done = 1'h0;
    tick = (st.div == DIV_W'(QC - 1));
    // a slave holding the clock low stretches the first high quarter
    hold = (st.q == 2'h1) && !scl_s && (st.ph != PH_IDLE);
    smp = tick && (st.q == 2'h1) && !hold;
    slot_end = tick && (st.q == 2'h3);
    if (st.ph == PH_IDLE) begin
      if (go) begin
        next_st.ph = PH_START;
        next_st.q = 2'h0;
        next_st.div = '0;
        next_st.rw = read_not_write;
        next_st.sel = bus_address_select_pin;
        next_st.idx = reg_index;
        next_st.left = byte_count;
        next_st.kind = K_ADDR_W;
        next_st.sh = dev_addr_byte(bus_address_select_pin, DIR_WRITE);
        next_st.nack = 1'h0;
        next_st.mack_low = 1'h0;
      end
    end else if (!hold) begin
      next_st.div = tick ? '0 : st.div + DIV_W'(1);
      if (tick) begin
        next_st.q = st.q + 2'h1;
      end
    end
    if (smp && st.ph == PH_RACK) begin
      next_st.nack = sda_s;
    end
    if (smp && st.ph == PH_RXB) begin
      next_st.sh = {st.sh[6:0], sda_s};
    end
    if (slot_end) begin
      next_st.bitc = 3'h7;
      case (st.ph)
        PH_START: next_st.ph = PH_TXB;
        PH_TXB: begin
          if (st.bitc == 3'h0) begin
            next_st.ph = PH_RACK;
          end else begin
            next_st.bitc = st.bitc - 3'h1;
            next_st.sh = {st.sh[6:0], 1'h0};
          end
        end
        PH_RACK: begin
          if (st.nack) begin
            next_st.ph = PH_STOP;
          end else begin
            case (st.kind)
              K_ADDR_W: begin
                next_st.sh = st.idx;
                next_st.kind = K_INDEX;
                next_st.ph = PH_TXB;
              end
              K_ADDR_R: next_st.ph = PH_RXB;
              default: begin
                if (st.kind == K_INDEX && st.rw) begin
                  next_st.ph = PH_START;
                  next_st.kind = K_ADDR_R;
                  next_st.sh = dev_addr_byte(st.sel, DIR_READ);
                end else if (st.left == 8'h0) begin
                  next_st.ph = PH_STOP;
                end else begin
                  next_st.sh = wr_data;
                  next_st.wr_take = 1'h1;
                  next_st.left = st.left - 8'h1;
                  next_st.kind = K_DATA_W;
                  next_st.ph = PH_TXB;
                end
              end
            endcase
          end
        end
        PH_RXB: begin
          if (st.bitc == 3'h0) begin
            next_st.rd_data = st.sh;
            next_st.rd_valid = 1'h1;
            next_st.left = (st.left == 8'h0) ? 8'h0 : st.left - 8'h1;
            next_st.mack_low = (st.left > 8'h1);
            next_st.ph = PH_MACK;
          end else begin
            next_st.bitc = st.bitc - 3'h1;
          end
        end
        PH_MACK: next_st.ph = st.mack_low ? PH_RXB : PH_STOP;
        PH_STOP: begin
          next_st.ph = PH_IDLE;
          next_st.done = 1'h1;
        end
        default: next_st.ph = PH_IDLE;
      endcase
    end
    {next_st.scl_low, next_st.sda_low} =
        line_drive(next_st.ph, next_st.q, next_st.sh[7], next_st.mack_low,
                   next_st.kind == K_ADDR_R);
    // length of the current low phase of the serial clock, for the rate check
    next_st.low_cnt = st.scl_low ? st.low_cnt + (DIV_W + 2)'(1) : '0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // open drain: only ever pull low, the pull-ups make the high level
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
  assign scl_oe = st.scl_low;
  assign sda_oe = st.sda_low;
  assign busy = (st.ph != PH_IDLE);
  assign done = st.done;
  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign wr_take = st.wr_take;
  assign nack_error = st.nack;

  sequence s_rack_end(byte_kind_t k);
    st.ph == PH_RACK && st.kind == k && slot_end && !st.nack;
  endsequence

  sequence s_into_stop;
    st.ph == PH_STOP && st.q == 2'h0;
  endsequence

  a_ack_held: assert property (@(posedge clk) disable iff (!nrst)
    (st.ph == PH_MACK && st.mack_low && st.q == 2'h1) |-> sda_oe && !scl_oe)
    else $error("master ack not held through clock high");
  a_nack_release: assert property (@(posedge clk) disable iff (!nrst)
    (st.ph == PH_MACK && !st.mack_low) |-> !sda_oe)
    else $error("master nack drives data low");
  a_nack_abandon: assert property (@(posedge clk) disable iff (!nrst)
    (st.ph == PH_RACK && slot_end && st.nack) |=> s_into_stop ##[1:600] st.ph == PH_IDLE)
    else $error("missing ack did not end the transfer");
  a_addr_write: assert property (@(posedge clk) disable iff (!nrst)
    (st.ph == PH_IDLE && go) |=> st.sh == {DEV_ADDR_HI, $past(bus_address_select_pin), 2'h0})
    else $error("wrong write address byte");
  a_read_restart: assert property (@(posedge clk) disable iff (!nrst)
    (s_rack_end(K_INDEX) and st.rw) |=> st.ph == PH_START && st.sh[0] && st.sh[2] == st.sel)
    else $error("read not preceded by repeated start with read bit");
  a_index_next: assert property (@(posedge clk) disable iff (!nrst)
    s_rack_end(K_ADDR_W) |=> st.ph == PH_TXB && st.kind == K_INDEX && st.sh == st.idx)
    else $error("index byte not sent after address");
  a_write_next: assert property (@(posedge clk) disable iff (!nrst)
    (s_rack_end(K_DATA_W) and st.left != 8'h0) |=> wr_take && st.sh == $past(wr_data))
    else $error("next write byte not loaded");
  a_write_open: assert property (@(posedge clk) disable iff (!nrst)
    (s_rack_end(K_DATA_W) and st.left == 8'h0) |=> s_into_stop)
    else $error("write not closed by stop");
  a_last_nack: assert property (@(posedge clk) disable iff (!nrst)
    rd_valid |-> st.mack_low == (st.left != 8'h0))
    else $error("ack choice does not match remaining count");
  a_sda_steady: assert property (@(posedge clk) disable iff (!nrst)
    (st.q == 2'h2 && (st.ph == PH_TXB || st.ph == PH_MACK)) |-> $stable(sda_oe) && !scl_oe)
    else $error("data moved while clock high");
  a_start_edge: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(sda_oe) && st.ph == PH_START) |-> !scl_oe ##1 !scl_oe)
    else $error("start not made with clock high");
  a_stop_edge: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(sda_oe) && st.ph == PH_STOP) |-> !scl_oe)
    else $error("stop not made with clock high");
  a_scl_rate: assert property (@(posedge clk) disable iff (!nrst)
    $fell(scl_oe) |-> st.low_cnt >= (DIV_W + 2)'(2 * QC - 1))
    else $error("serial clock low phase too short");
endmodule : tuner_link_master

// file: hdl/tuner_link_pkg.sv
/*
  Shared constants and types for the two-wire host that drives the tuner's
  serial register port. Assumes a 50 MHz system clock.
*/
package tuner_link_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // fastest serial clock the tuner accepts is 400 kHz
  localparam int SCL_MIN_PERIOD_NS = 2500;
  // least time rounds up, so the bus never runs faster than allowed
  localparam int QUARTER_CYC = (SCL_MIN_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] DEV_ADDR_HI = 5'h18;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic [1:0] PIN_IDLE = 2'h3;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_START = 3'h1,
    PH_TXB = 3'h3,
    PH_RACK = 3'h2,
    PH_RXB = 3'h6,
    PH_MACK = 3'h7,
    PH_STOP = 3'h5
  } phase_t;

  typedef enum logic [2:0] {
    K_ADDR_W = 3'h0,
    K_INDEX = 3'h1,
    K_DATA_W = 3'h3,
    K_ADDR_R = 3'h2
  } byte_kind_t;

  function automatic logic [7:0] dev_addr_byte(input logic sel, input logic dir);
    return {DEV_ADDR_HI, sel, 1'h0, dir};
  endfunction : dev_addr_byte
endpackage : tuner_link_pkg

// file: hdl/tuner_pin_sync.sv
/*
  Two-flop synchroniser for the sensed bus pins.
  Assumes the pins idle high, so the flops reset to one.
*/
module tuner_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] out;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // the first stage feeds only the second, never any logic
  always_comb begin
    next_st.meta = d;
    next_st.out = st.meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.out;
endmodule : tuner_pin_sync

// file: bench/tuner_dev_model.sv
/*
  Behavioural model of the tuner's two-wire register port.
  Assumes resolved open-drain wires with pull-ups; it pulls only by its enables.
*/
module tuner_dev_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic strap,
  input wire logic stretch,
  output logic sda_oe,
  output logic scl_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [256];
  logic [7:0] sh;
  logic [7:0] idx;
  int b;
  int nb;
  logic act, mine, rdr, rdp, mack;
  initial begin
    {sda_oe, scl_oe, act, mine, rdr, rdp, mack} = '0;
    foreach (regs[j]) regs[j] = 8'h00;
  end
  // idx is not cleared here, so it survives a repeated start
  always @(negedge sda) if (scl === 1'h1) begin
    act = 1'h1;
    b = 0;
    nb = 0;
    rdp = 1'h0;
    sda_oe = 1'h0;
  end
  always @(posedge sda) if (scl === 1'h1) act = 1'h0;
  always @(posedge scl) if (act) begin
    b = b + 1;
    if (!rdp && b < 9) sh = {sh[6:0], sda};
    if (rdp && b == 9) mack = !sda;
  end
  always @(negedge scl) if (act) begin
    if (b == 8 && !rdp) begin
      if (nb == 0) mine = sh[7:1] == {5'h18, strap, 1'h0};
      if (nb == 0) rdr = sh[0];
      if (nb == 1 && mine) idx = sh;
      if (nb > 1 && mine) regs[idx] = sh;
      if (nb > 1 && mine) idx = idx + 8'h01;
      sda_oe = mine;
      if (nb < 2) nb = nb + 1;
    end else if (b == 9) begin
      b = 0;
      if (rdp && mack) idx = idx + 8'h01;
      rdp = mine && rdr && (!rdp || mack);
      sda_oe = rdp && !regs[idx][7];
    end else if (rdp) sda_oe = b < 8 && !regs[idx][7 - b];
  end
  // slow mode: hold the clock low past a whole quarter
  always @(negedge scl) if (act && stretch) begin
    scl_oe = 1'h1;
    #200 scl_oe = 1'h0;
  end
endmodule : tuner_dev_model

// file: bench/tuner_link_master_tb.sv
/*
  Self-checking bench for tuner_link_master against tuner_dev_model.
  Assumes pull-ups on both wires; a reference memory predicts every read.
*/
module tuner_link_master_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, go, rnw, sel, strap, stretch;
  logic [7:0] idx, cnt, wd, seed, ri;
  logic wr_take, rd_valid, busy, done, nack_error;
  logic [7:0] rd_data;
  logic scl_oe, sda_oe, d_scl_oe, d_sda_oe, scl, sda;
  logic scl_out, sda_out;
  int n_mismatch = 0;
  int check_count = 0;
  int n_start = 0;
  int n_stop = 0;
  int mem [256];
  assign scl = !(scl_oe === 1'h1 || d_scl_oe === 1'h1);
  assign sda = !(sda_oe === 1'h1 || d_sda_oe === 1'h1);
  tuner_link_master #(.QC(4)) uut (.clk(clk), .nrst(nrst), .go(go), .read_not_write(rnw),
    .bus_address_select_pin(sel), .reg_index(idx), .byte_count(cnt), .wr_data(wd),
    .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .done(done),
    .nack_error(nack_error), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  tuner_dev_model dev (.scl(scl), .sda(sda), .strap(strap), .stretch(stretch),
    .sda_oe(d_sda_oe), .scl_oe(d_scl_oe));
  initial begin
    clk = 1'h0;
    forever #10 clk = !clk;
  end
  always @(negedge sda) if (scl === 1'h1) n_start++;
  always @(posedge sda) if (scl === 1'h1) n_stop++;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_num
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_num({24'h00_0000, got}, {24'h00_0000, exp});
  endtask : cmp_byte
  task automatic xfer(input logic r, input logic s, input logic [7:0] i,
                      input logic [7:0] n, input logic bad);
    int k, t, st0, sp0;
    logic [7:0] q [$];
    for (k = 0; k < n && !r; k++) begin
      seed = lfsr(seed);
      q.push_back(seed);
    end
    st0 = n_start;
    sp0 = n_stop;
    @(negedge clk);
    {rnw, sel, idx, cnt, go} = {r, s, i, n, 1'h1};
    wd = (q.size() > 0) ? q[0] : 8'h00;
    @(negedge clk);
    go = 1'h0;
    cmp_num(32'(busy), 1);
    k = 0;
    for (t = 0; t < 8000; t++) begin
      @(negedge clk);
      // a request while busy must change nothing
      go = t == 40;
      if (wr_take === 1'h1) begin
        k++;
        if (k < q.size()) wd = q[k];
      end
      if (rd_valid === 1'h1) begin
        cmp_byte(rd_data, 8'(mem[(i + k) % 256]));
        k++;
      end
      if (done === 1'h1) break;
    end
    if (t == 8000) begin
      n_mismatch++;
      stop_test();
    end
    cmp_num(k, bad ? 0 : (r ? ((n == 0) ? 1 : n) : n));
    cmp_num(32'(nack_error), 32'(bad));
    // open drain: the pins may only ever be pulled low
    cmp_num(32'({scl_out, sda_out}), 0);
    cmp_num(n_start - st0, (r && !bad) ? 2 : 1);
    cmp_num(n_stop - sp0, 1);
    for (k = 0; k < n && !r && !bad; k++) mem[(i + k) % 256] = q[k];
    for (k = 0; k < n; k++) begin
      cmp_byte(dev.regs[(i + k) % 256], 8'(mem[(i + k) % 256]));
    end
    repeat (20) @(negedge clk);
    cmp_num(32'(busy), 0);
  endtask : xfer
  initial begin
    {go, rnw, sel, idx, cnt, wd, strap, stretch} = '0;
    nrst = 1'h0;
    seed = 8'h32;
    foreach (mem[j]) mem[j] = 0;
    repeat (10) @(negedge clk);
    nrst = 1'h1;
    for (int s = 0; s < 2; s++) begin
      strap = s[0];
      xfer(1'h0, s[0], 8'hfe, 8'h03, 1'h0);
      xfer(1'h1, s[0], 8'hfe, 8'h03, 1'h0);
    end
    xfer(1'h0, 1'h1, 8'h10, 8'h00, 1'h0);
    xfer(1'h1, 1'h1, 8'hff, 8'h00, 1'h0);
    xfer(1'h0, 1'h0, 8'h20, 8'h02, 1'h1);
    xfer(1'h0, 1'h1, 8'h20, 8'h02, 1'h0);
    stretch = 1'h1;
    xfer(1'h1, 1'h1, 8'h20, 8'h02, 1'h0);
    stretch = 1'h0;
    for (int j = 0; j < 3; j++) begin
      seed = lfsr(seed);
      ri = seed;
      xfer(1'h0, 1'h1, ri, {6'h00, seed[1:0]} + 8'h01, 1'h0);
      xfer(1'h1, 1'h1, ri, 8'h04, 1'h0);
    end
    stop_test();
  end
endmodule : tuner_link_master_tb
